// *** src/ssc_hold_timer.sv ***
// consecutive-cycle hold timer for the button override
`timescale 1ns/1ps
`default_nettype none
module ssc_hold_timer import ssc_pkg::*; #(
  parameter int unsigned LIMIT = OVERRIDE_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  output logic fire
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_ff;
  logic fire_ff;
  logic [W-1:0] nxt_cnt;
  logic nxt_fire;

  if (LIMIT < 2) begin : g_chk
    $error("hold timer limit too small");
  end

  // saturates so one long press fires once
  assign nxt_cnt = !run ? '0 : (cnt_ff == W'(LIMIT)) ? cnt_ff : cnt_ff + W'(1);
  assign nxt_fire = run && (cnt_ff == W'(LIMIT - 1));
  assign fire = fire_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      fire_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      fire_ff <= nxt_fire;
    end
  end
endmodule
`default_nettype wire

// *** src/ssc_pkg.sv ***
// constants and types for the sleep state controller
package ssc_pkg;
  // timing
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned OVERRIDE_TIME_MS = 4000;
  localparam int unsigned OVERRIDE_CYCLES = OVERRIDE_TIME_MS * (CLK_FREQ_HZ / 1000);
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PM_EN = 12'h004;
  localparam logic [11:0] ADDR_GPE_EN = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_STATE = 12'h010;
  // control register fields
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_GO_BIT = 3;
  localparam int CTRL_POLICY_BIT = 4;
  localparam int CTRL_CPU_SLEEP_N_BIT = 5;
  // pm enable field
  localparam int PM_ALARM_BIT = 0;
  // general event enable fields
  localparam int GPE_USB_BIT = 0;
  localparam int GPE_RING_BIT = 1;
  localparam int GPE_AUDIO_BIT = 2;
  localparam int GPE_EXTPME_BIT = 3;
  localparam int GPE_INTPME_BIT = 4;
  localparam int GPE_SMBA_BIT = 5;
  localparam int GPE_GPI_LSB = 8;
  // status flags, write one to clear
  localparam int STS_WAKE_BIT = 0;
  localparam int STS_BUTTON_BIT = 1;
  localparam int STS_RING_BIT = 2;
  localparam int STS_ALARM_BIT = 3;
  localparam int STS_CORE_FAIL_BIT = 4;
  localparam int STS_RES_FAIL_BIT = 5;
  localparam int STS_W = 6;
  // reset values
  localparam logic [2:0] CTRL_TYPE_RST = 3'h0;
  localparam logic [15:0] GPE_EN_RST = 16'h0000;
  localparam logic [STS_W-1:0] STS_RST = 6'h00;
  localparam logic [4:0] DRIVE_RST_N = 5'h1F;
  // sleep type codes; other codes are reserved
  typedef enum logic [2:0] {
    SSC_TYPE_S1 = 3'h1,
    SSC_TYPE_S3 = 3'h3,
    SSC_TYPE_S4 = 3'h4,
    SSC_TYPE_S5 = 3'h5
  } ssc_type_e;
  typedef enum logic [2:0] {
    SSC_ST_S0 = 3'h0,
    SSC_ST_C2 = 3'h1,
    SSC_ST_S1 = 3'h2,
    SSC_ST_S3 = 3'h3,
    SSC_ST_S4 = 3'h4,
    SSC_ST_S5 = 3'h5,
    SSC_ST_OFF = 3'h6
  } ssc_state_e;
  typedef enum logic [1:0] {
    SSC_CAUSE_NONE = 2'h0,
    SSC_CAUSE_SW = 2'h1,
    SSC_CAUSE_OVR = 2'h2,
    SSC_CAUSE_PFAIL = 2'h3
  } ssc_cause_e;
endpackage

// *** src/ssc_sleep_controller.sv ***
// sleep state sequencer with apb registers
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ssc_sleep_controller import ssc_pkg::*; #(
  parameter int unsigned NGPI = 8,
  parameter logic [7:0] CORE_WELL_MASK = 8'h0F,
  parameter int unsigned OVR_CYCLES = OVERRIDE_CYCLES
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor
  input wire logic cpu_stop_grant,
  output logic cpu_stop_clock_n,
  output logic cpu_sleep_n,
  output logic throttle_inhibit,
  // power rails
  output logic noncritical_rail_off_n,
  output logic memory_rail_off_n,
  output logic soft_off_rail_n,
  // power monitors
  input wire logic core_power_good,
  input wire logic resume_well_reset_n,
  // wake sources
  input wire logic power_button_n,
  input wire logic ring_indicate_n,
  input wire logic ext_power_event_n,
  input wire logic smbus_alert_n,
  input wire logic smbus_wake_msg,
  input wire logic smbus_reset_msg,
  input wire logic usb_port_a_wake,
  input wire logic audio_link_wake,
  input wire logic internal_power_event,
  input wire logic alarm_event,
  input wire logic [NGPI-1:0] general_inputs
);
  if (NGPI < 1 || NGPI > 8) begin : g_chk
    $error("NGPI must be 1 to 8");
  end
  function automatic logic valid_type(input logic [2:0] t);
    valid_type = (t == SSC_TYPE_S1) || (t == SSC_TYPE_S3) ||
                 (t == SSC_TYPE_S4) || (t == SSC_TYPE_S5);
  endfunction
  function automatic ssc_state_e type_state(input logic [2:0] t);
    case (t)
      SSC_TYPE_S1: type_state = SSC_ST_S1;
      SSC_TYPE_S3: type_state = SSC_ST_S3;
      SSC_TYPE_S4: type_state = SSC_ST_S4;
      default: type_state = SSC_ST_S5;
    endcase
  endfunction
  // asserted-high {stop, cpu sleep, s3, s4, s5}
  function automatic logic [4:0] drive_of(input ssc_state_e s, input logic opt);
    case (s)
      SSC_ST_S0: drive_of = 5'h00;
      SSC_ST_C2: drive_of = 5'h10;
      SSC_ST_S1: drive_of = {1'b1, opt, 3'h0};
      SSC_ST_S3: drive_of = 5'h14;
      SSC_ST_S4: drive_of = 5'h16;
      SSC_ST_S5: drive_of = 5'h17;
      SSC_ST_OFF: drive_of = 5'h17;
      default: drive_of = 5'h00;
    endcase
  endfunction
  // registers
  ssc_state_e state_ff, nxt_state;
  ssc_cause_e cause_ff, nxt_cause;
  logic [2:0] type_ff;
  logic go_ff, policy_ff, cpu_sleep_n_opt_ff, alarm_en_ff;
  logic [15:0] gpe_en_ff;
  logic [STS_W-1:0] sts_ff, nxt_sts;
  logic failed_s4_ff, ring_loss_ff;
  logic rsm_ff, pg_ff, btn_ff, pme_ff, ri_ff;
  logic [4:0] drive_n_ff;
  logic throttle_inhibit_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic fire;
  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready_ff;
  wire wr = access && pwrite;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_pm = paddr == ADDR_PM_EN;
  wire hit_gpe = paddr == ADDR_GPE_EN;
  wire hit_sts = paddr == ADDR_STATUS;
  wire hit_state = paddr == ADDR_STATE;
  wire mapped = hit_ctrl || hit_pm || hit_gpe || hit_sts || hit_state;
  wire [2:0] wr_type = pwdata[CTRL_TYPE_LSB +: 3];
  wire [31:0] ctrl_rd = {26'h0, cpu_sleep_n_opt_ff, policy_ff, go_ff, type_ff};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_pm ? {31'h0, alarm_en_ff} :
                       hit_gpe ? {16'h0, gpe_en_ff} :
                       hit_sts ? {26'h0, sts_ff} :
                       hit_state ? {27'h0, cause_ff, state_ff} : 32'h0;
  // type must come in the same write as go; that write also sets type_ff
  wire sw_go = wr && hit_ctrl && pwdata[CTRL_GO_BIT] && valid_type(wr_type) &&
               state_ff == SSC_ST_S0;
  // edges; inputs are synchronous already
  wire rsm_fall = rsm_ff && !resume_well_reset_n;
  wire pg_fall = pg_ff && !core_power_good;
  wire btn_fall = btn_ff && !power_button_n;
  wire pme_fall = pme_ff && !ext_power_event_n;
  wire ri_fall = ri_ff && !ring_indicate_n;
  wire powered = resume_well_reset_n;
  // state groups
  wire asleep = state_ff == SSC_ST_S1 || state_ff == SSC_ST_S3 ||
                state_ff == SSC_ST_S4 || state_ff == SSC_ST_S5;
  wire core_off = state_ff == SSC_ST_S3 || state_ff == SSC_ST_S4 || state_ff == SSC_ST_S5;
  wire ovr_s5 = state_ff == SSC_ST_S5 && cause_ff == SSC_CAUSE_OVR;
  wire after_loss = cause_ff == SSC_CAUSE_PFAIL;
  // wake sources
  wire [NGPI-1:0] core_mask = core_off ? CORE_WELL_MASK[NGPI-1:0] : '0;
  wire gpi_wake = |(general_inputs & gpe_en_ff[GPE_GPI_LSB +: NGPI] & ~core_mask);
  wire alarm_wake = sts_ff[STS_ALARM_BIT] && alarm_en_ff;
  wire ring_wake = (ri_fall || sts_ff[STS_RING_BIT]) && gpe_en_ff[GPE_RING_BIT];
  wire smba_wake = !smbus_alert_n && gpe_en_ff[GPE_SMBA_BIT] &&
                   state_ff != SSC_ST_S5;
  wire std_wake = alarm_wake || gpi_wake || ring_wake || smba_wake ||
                  (pme_fall && gpe_en_ff[GPE_EXTPME_BIT]) ||
                  (usb_port_a_wake && gpe_en_ff[GPE_USB_BIT]) ||
                  (audio_link_wake && gpe_en_ff[GPE_AUDIO_BIT]) ||
                  (internal_power_event && gpe_en_ff[GPE_INTPME_BIT]);
  // override S5 keeps only the always-on sources
  wire gated_wake = ovr_s5 ? 1'b0 :
                    after_loss ? (ring_wake || alarm_wake) : std_wake;
  wire wake = asleep && (btn_fall || smbus_wake_msg || smbus_reset_msg ||
                         gated_wake);
  // override timer; not run in S5, where a press wakes instead
  wire hold_run = !power_button_n && powered &&
                  state_ff != SSC_ST_S5 && state_ff != SSC_ST_OFF;
  ssc_hold_timer #(.LIMIT(OVR_CYCLES)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .run(hold_run),
    .fire(fire)
  );
  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cause = cause_ff;
    if (!powered) begin
      nxt_state = SSC_ST_OFF;
      nxt_cause = SSC_CAUSE_PFAIL;
    end else if (fire) begin
      // no stop grant wait, no clock but our own
      nxt_state = SSC_ST_S5;
      nxt_cause = SSC_CAUSE_OVR;
    end else begin
      case (state_ff)
        SSC_ST_S0: begin
          if (sw_go) begin
            nxt_state = SSC_ST_C2;
          end
        end
        SSC_ST_C2: begin
          if (cpu_stop_grant) begin
            nxt_state = type_state(type_ff);
            nxt_cause = SSC_CAUSE_SW;
          end
        end
        SSC_ST_S1, SSC_ST_S3, SSC_ST_S4, SSC_ST_S5: begin
          if (wake) begin
            nxt_state = SSC_ST_S0;
            nxt_cause = SSC_CAUSE_NONE;
          end
        end
        SSC_ST_OFF: begin
          if (!policy_ff) begin
            nxt_state = SSC_ST_S0;
            nxt_cause = SSC_CAUSE_NONE;
          end else begin
            nxt_state = failed_s4_ff ? SSC_ST_S4 : SSC_ST_S5;
          end
        end
        default: nxt_state = SSC_ST_S0;
      endcase
    end
  end
  // status: set wins over write-one-clear
  wire [STS_W-1:0] sts_set;
  assign sts_set[STS_WAKE_BIT] = wake && powered && !fire;
  assign sts_set[STS_BUTTON_BIT] = btn_fall;
  assign sts_set[STS_RING_BIT] = ri_fall ||
                                 (state_ff == SSC_ST_OFF && powered && ring_loss_ff);
  assign sts_set[STS_ALARM_BIT] = alarm_event;
  assign sts_set[STS_CORE_FAIL_BIT] = pg_fall;
  assign sts_set[STS_RES_FAIL_BIT] = rsm_fall;
  wire [STS_W-1:0] sts_clr = (wr && hit_sts) ? pwdata[STS_W-1:0] : '0;
  // no resume power means no button or alarm history
  wire [STS_W-1:0] sts_hold = powered ? '0 :
                              (STS_W'(1) << STS_BUTTON_BIT) | (STS_W'(1) << STS_ALARM_BIT);
  assign nxt_sts = ((sts_ff & ~sts_clr) | sts_set) & ~sts_hold;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SSC_ST_S0;
      cause_ff <= SSC_CAUSE_NONE;
    end else begin
      state_ff <= nxt_state;
      cause_ff <= nxt_cause;
    end
  end
  // control; go reads back while a sleep is underway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_ff <= CTRL_TYPE_RST;
      go_ff <= 1'b0;
      policy_ff <= 1'b0;
      cpu_sleep_n_opt_ff <= 1'b0;
    end else begin
      if (wr && hit_ctrl) begin
        type_ff <= wr_type;
        policy_ff <= pwdata[CTRL_POLICY_BIT];
        cpu_sleep_n_opt_ff <= pwdata[CTRL_CPU_SLEEP_N_BIT];
      end
      go_ff <= sw_go || (go_ff && nxt_state != SSC_ST_S0);
    end
  end
  // enables live in the always-on well: kept through loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_en_ff <= 1'b0;
      gpe_en_ff <= GPE_EN_RST;
    end else begin
      if (wr && hit_pm) begin
        alarm_en_ff <= pwdata[PM_ALARM_BIT];
      end
      if (wr && hit_gpe) begin
        gpe_en_ff <= pwdata[15:0];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_ff <= STS_RST;
      failed_s4_ff <= 1'b0;
      ring_loss_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      if (rsm_fall) begin
        failed_s4_ff <= state_ff == SSC_ST_S4;
      end
      ring_loss_ff <= state_ff == SSC_ST_OFF && (ring_loss_ff || !ring_indicate_n);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsm_ff <= 1'b1;
      pg_ff <= 1'b1;
      btn_ff <= 1'b1;
      pme_ff <= 1'b1;
      ri_ff <= 1'b1;
    end else begin
      rsm_ff <= resume_well_reset_n;
      pg_ff <= core_power_good;
      btn_ff <= power_button_n;
      pme_ff <= ext_power_event_n;
      ri_ff <= ring_indicate_n;
    end
  end
  // outputs follow the next state so they line up with state_ff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_n_ff <= DRIVE_RST_N;
      throttle_inhibit_ff <= 1'b0;
    end else begin
      drive_n_ff <= ~drive_of(nxt_state, cpu_sleep_n_opt_ff);
      throttle_inhibit_ff <= nxt_state != SSC_ST_S0;
    end
  end
  // zero-wait apb: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      prdata_ff <= setup ? rd_mux : 32'h0;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cpu_stop_clock_n = drive_n_ff[4];
  assign cpu_sleep_n = drive_n_ff[3];
  assign noncritical_rail_off_n = drive_n_ff[2];
  assign memory_rail_off_n = drive_n_ff[1];
  assign soft_off_rail_n = drive_n_ff[0];
  assign throttle_inhibit = throttle_inhibit_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_go_stop_clk: assert property (sw_go && powered && !fire |=>
    state_ff == SSC_ST_C2 && !cpu_stop_clock_n && noncritical_rail_off_n)
    else $error("sleep request did not enter stop clock");
  a_c2_waits: assert property (state_ff == SSC_ST_C2 && !cpu_stop_grant && powered && !fire
    |=> state_ff == SSC_ST_C2)
    else $error("left stop clock without stop grant");
  a_sleep_blocks: assert property (go_ff |-> throttle_inhibit)
    else $error("throttle not inhibited during sleep");
  a_override_s5: assert property (fire && powered |=> state_ff == SSC_ST_S5 &&
    !soft_off_rail_n && !memory_rail_off_n)
    else $error("override did not reach S5");
  a_s1_stop: assert property (state_ff == SSC_ST_S1 |-> !cpu_stop_clock_n &&
    noncritical_rail_off_n)
    else $error("S1 outputs wrong");
  a_s3_rail: assert property (state_ff == SSC_ST_S3 |-> !noncritical_rail_off_n &&
    memory_rail_off_n && soft_off_rail_n)
    else $error("S3 rails wrong");
  a_s4_rails: assert property (state_ff == SSC_ST_S4 |-> !noncritical_rail_off_n &&
    !memory_rail_off_n && soft_off_rail_n)
    else $error("S4 rails wrong");
  a_s5_rails: assert property (state_ff == SSC_ST_S5 |-> !noncritical_rail_off_n &&
    !memory_rail_off_n && !soft_off_rail_n)
    else $error("S5 rails wrong");
  a_no_sw_off: assert property (powered |=> state_ff != SSC_ST_OFF || !$past(powered))
    else $error("power off reached while powered");
  a_wake_flag: assert property (asleep && wake && powered && !fire |=>
    state_ff == SSC_ST_S0 && sts_ff[STS_WAKE_BIT])
    else $error("wake did not reach S0 with flag");
  a_ovr_smba: assert property (ovr_s5 && !btn_fall && !smbus_wake_msg && !smbus_reset_msg
    && powered |=> state_ff == SSC_ST_S5)
    else $error("override S5 woke from a gated source");
  a_button_held: assert property (!powered |=> !sts_ff[STS_BUTTON_BIT] &&
    !sts_ff[STS_ALARM_BIT])
    else $error("button or alarm flag survived loss");
  a_fail_flags: assert property ($fell(core_power_good) |=> sts_ff[STS_CORE_FAIL_BIT])
    else $error("core power fail flag not set");
  a_policy_s5: assert property (state_ff == SSC_ST_OFF && powered && policy_ff &&
    !failed_s4_ff |=> state_ff == SSC_ST_S5 ##1 state_ff != SSC_ST_OFF)
    else $error("policy did not hold S5");
endmodule
`default_nettype wire

// *** testbench/ssc_cpu_model.sv ***
// processor stop-grant responder for the sleep controller bench
`timescale 1ns/1ps
`default_nettype none
module ssc_cpu_model #(
  parameter int unsigned DELAY = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // processor side
  input wire logic cpu_stop_clock_n,
  output logic cpu_stop_grant
);
  logic [7:0] wait_ff;
  logic grant_ff;
  // grant only after a real wait, so the rails must not move before it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 8'h00;
      grant_ff <= 1'b0;
    end else if (cpu_stop_clock_n) begin
      wait_ff <= 8'h00;
      grant_ff <= 1'b0;
    end else begin
      // saturate so a long sleep never drops the grant
      if (wait_ff != 8'hFF) begin
        wait_ff <= wait_ff + 8'h01;
      end
      grant_ff <= (wait_ff >= 8'(DELAY));
    end
  end
  assign cpu_stop_grant = grant_ff;
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the sleep state controller
`timescale 1ns/1ps
`default_nettype none
module tb import ssc_pkg::*;;
  localparam int unsigned OVR = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic stop_grant, cpu_stop_clock_n_n, cpu_sleep_n_n, thr_inh, nc_n, mem_n, soft_n;
  logic core_good, res_n, btn_n, ring_n, pme_n, alert_n, wake_msg, alarm;
  logic usb, audio, ipme, rst_msg;
  logic [7:0] gpi;
  int n_mismatch, n_compared;
  ssc_type_e ty [4] = '{SSC_TYPE_S1, SSC_TYPE_S3, SSC_TYPE_S4, SSC_TYPE_S5};
  ssc_state_e st [4] = '{SSC_ST_S1, SSC_ST_S3, SSC_ST_S4, SSC_ST_S5};
  logic [2:0] rails [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
  logic [2:0] rsv [4] = '{3'h0, 3'h2, 3'h6, 3'h7};

  ssc_sleep_controller #(.OVR_CYCLES(OVR)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_stop_grant(stop_grant), .cpu_stop_clock_n(cpu_stop_clock_n_n), .cpu_sleep_n(cpu_sleep_n_n),
    .throttle_inhibit(thr_inh), .noncritical_rail_off_n(nc_n), .memory_rail_off_n(mem_n),
    .soft_off_rail_n(soft_n), .core_power_good(core_good), .resume_well_reset_n(res_n),
    .power_button_n(btn_n), .ring_indicate_n(ring_n), .ext_power_event_n(pme_n),
    .smbus_alert_n(alert_n), .smbus_wake_msg(wake_msg), .smbus_reset_msg(rst_msg),
    .usb_port_a_wake(usb), .audio_link_wake(audio), .internal_power_event(ipme),
    .alarm_event(alarm), .general_inputs(gpi));

  ssc_cpu_model #(.DELAY(3)) cpu (
    .pclk(pclk), .presetn(presetn), .cpu_stop_clock_n(cpu_stop_clock_n_n), .cpu_stop_grant(stop_grant));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; the answer is taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      $display("Error at %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll the state register; gives up after a bounded number of reads
  task automatic wait_state(input logic [2:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATE, 32'h0);
      n++;
    end while (rd[2:0] !== exp && n < 40);
    chk({29'h0, rd[2:0]}, {29'h0, exp});
  endtask

  initial begin
    int n;
    n_mismatch = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    core_good = 1'b1;
    res_n = 1'b1;
    btn_n = 1'b1;
    ring_n = 1'b1;
    pme_n = 1'b1;
    alert_n = 1'b1;
    wake_msg = 1'b0;
    alarm = 1'b0;
    usb = 1'b0;
    audio = 1'b0;
    ipme = 1'b0;
    rst_msg = 1'b0;
    gpi = 8'h00;
    tick(3);
    presetn <= 1'b1;
    // reset values, then an unmapped write that must be refused
    for (int a = 0; a < 5; a++) begin
      apb(1'b0, 12'(a * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    // every sleep type, entered through stop clock, left by the button
    apb(1'b1, ADDR_GPE_EN, 32'h1 << GPE_SMBA_BIT);
    foreach (ty[i]) begin
      apb(1'b1, ADDR_CTRL, (32'h1 << CTRL_GO_BIT) | (32'h1 << CTRL_CPU_SLEEP_N_BIT) | 32'(ty[i]));
      n = 0;
      while (cpu_stop_clock_n_n !== 1'b0 && n < 20) begin
        @(negedge pclk);
        n++;
      end
      chk({28'h0, cpu_stop_clock_n_n, nc_n, mem_n, soft_n}, 32'h7);
      chk({31'h0, thr_inh}, 32'h1);
      wait_state(st[i]);
      @(negedge pclk);
      chk({29'h0, nc_n, mem_n, soft_n}, {29'h0, rails[i]});
      chk({30'h0, cpu_stop_clock_n_n, cpu_sleep_n_n}, (i == 0) ? 32'h0 : 32'h1);
      tick(1);
      alarm <= 1'b1;
      alert_n <= (i != 3);
      tick(1);
      alarm <= 1'b0;
      tick(2);
      alert_n <= 1'b1;
      wait_state(st[i]);
      btn_n <= 1'b0;
      tick(2);
      btn_n <= 1'b1;
      wait_state(SSC_ST_S0);
      chk({31'h0, thr_inh}, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({31'h0, rd[STS_WAKE_BIT]}, 32'h1);
      apb(1'b1, ADDR_STATUS, 32'h3F);
    end
    // reserved codes never leave S0, even with go set
    foreach (rsv[i]) begin
      apb(1'b1, ADDR_CTRL, (32'h1 << CTRL_GO_BIT) | 32'(rsv[i]));
      tick(6);
      wait_state(SSC_ST_S0);
    end
    // held button forces S5; enabled ring and pme must not wake it, the wake message does
    apb(1'b1, ADDR_GPE_EN, (32'h1 << GPE_RING_BIT) | (32'h1 << GPE_EXTPME_BIT));
    btn_n <= 1'b0;
    tick(OVR + 4);
    btn_n <= 1'b1;
    wait_state(SSC_ST_S5);
    chk({30'h0, rd[4:3]}, {30'h0, SSC_CAUSE_OVR});
    chk({29'h0, nc_n, mem_n, soft_n}, 32'h0);
    ring_n <= 1'b0;
    pme_n <= 1'b0;
    tick(3);
    ring_n <= 1'b1;
    pme_n <= 1'b1;
    wait_state(SSC_ST_S5);
    wake_msg <= 1'b1;
    tick(1);
    wake_msg <= 1'b0;
    wait_state(SSC_ST_S0);
    // power loss with ring held low and events that must not latch
    // ring falls first and its flag is cleared, so only the loss path can set it
    ring_n <= 1'b0;
    tick(2);
    apb(1'b1, ADDR_STATUS, 32'h3F);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_POLICY_BIT);
    core_good <= 1'b0;
    tick(2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h1 << STS_CORE_FAIL_BIT);
    res_n <= 1'b0;
    tick(3);
    btn_n <= 1'b0;
    alarm <= 1'b1;
    tick(1);
    alarm <= 1'b0;
    tick(1);
    btn_n <= 1'b1;
    tick(2);
    res_n <= 1'b1;
    core_good <= 1'b1;
    ring_n <= 1'b1;
    wait_state(SSC_ST_S0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h35);
    // return policy both ways; alarm enable survives the loss
    apb(1'b1, ADDR_GPE_EN, 32'h0);
    apb(1'b1, ADDR_PM_EN, 32'h1 << PM_ALARM_BIT);
    for (int p = 1; p >= 0; p--) begin
      apb(1'b1, ADDR_CTRL, 32'(p) << CTRL_POLICY_BIT);
      res_n <= 1'b0;
      core_good <= 1'b0;
      tick(4);
      res_n <= 1'b1;
      core_good <= 1'b1;
      wait_state((p == 1) ? SSC_ST_S5 : SSC_ST_S0);
      alarm <= 1'b1;
      tick(1);
      alarm <= 1'b0;
      wait_state(SSC_ST_S0);
    end
    // a loss in S4 comes back to S4 under the stay-off policy
    apb(1'b1, ADDR_STATUS, 32'h3F);
    apb(1'b1, ADDR_CTRL, (32'h1 << CTRL_GO_BIT) | (32'h1 << CTRL_POLICY_BIT) | 32'(SSC_TYPE_S4));
    wait_state(SSC_ST_S4);
    res_n <= 1'b0;
    core_good <= 1'b0;
    tick(4);
    res_n <= 1'b1;
    core_good <= 1'b1;
    wait_state(SSC_ST_S4);
    btn_n <= 1'b0;
    tick(2);
    btn_n <= 1'b1;
    wait_state(SSC_ST_S0);
    finish_test();
  end

  // the whole sequence needs a few hundred cycles
  initial begin
    #1ms;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
